// >>> core/pwg_pkg.sv
// Purpose: Shared constants and carrier types for the peripheral write guard
// Assumes: Single clock, simple one-cycle request bus from the CPU side
// Notes:   Peripheral count and reset protection vector are plain defaults
package pwg_pkg;
   localparam int          NPER          = 8;
   localparam int          AW            = 12;
   localparam int          DW            = 32;
   localparam logic [AW-1:0] OFF_CLR     = 12'h000;
   localparam logic [AW-1:0] OFF_SET     = 12'h004;
   localparam logic [NPER-1:0] PROT_RST  = 8'h00;

   typedef struct packed {
      logic            valid;
      logic            write;
      logic            guard_sel;
      logic [2:0]      per_idx;
      logic [AW-1:0]   addr;
      logic [DW-1:0]   wdata;
   } pwg_req_t;

   typedef struct packed {
      logic            done;
      logic            err;
      logic [DW-1:0]   rdata;
   } pwg_rsp_t;
endpackage

// >>> core/pwg_alias_dec.sv
// Purpose: Decode one guard-register write into new protect vector and error
// Assumes: Caller only asserts wr when the guard registers are written
// Notes:   Purely combinational
`timescale 1ns/10ps
module pwg_alias_dec (
   input  wire logic                       wr,
   input  wire logic                       is_set,
   input  wire logic [pwg_pkg::NPER-1:0]   prot,
   input  wire logic [pwg_pkg::NPER-1:0]   ones,
   output logic      [pwg_pkg::NPER-1:0]   prot_nxt,
   output logic                            dbl_err
);
   always_comb begin
      prot_nxt = prot;
      dbl_err  = 1'b0;
      if (wr && is_set) begin
         prot_nxt = prot | ones;
         dbl_err  = |(prot & ones);
      end else if (wr) begin
         prot_nxt = prot & ~ones;
         dbl_err  = |(~prot & ones);
      end
   end
endmodule

// >>> core/pwg_top.sv
// Purpose: Peripheral access guard with clear and set alias registers
// Assumes: Requests are one-cycle pulses; answer one cycle later
// Notes:   Guard registers use alias offsets; unprotected peripheral writes are forwarded
// Behaviour
// - Writing one to a clear alias bit unprotects that peripheral.
// - Writing one to a set alias bit protects that peripheral.
// - Both alias registers read back the same protect vector.
// - Writes to protected peripherals are dropped and answered with error.
// - Clearing an already unprotected peripheral answers with error.
// - Setting an already protected peripheral answers with error.
// - Zero bits written to either alias leave protect bits unchanged.
`timescale 1ns/10ps
module pwg_top (
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire pwg_pkg::pwg_req_t          req,
   output pwg_pkg::pwg_rsp_t               rsp,
   output logic                            per_wr_stb,
   output logic [2:0]                      per_wr_idx,
   output logic [pwg_pkg::AW-1:0]          per_wr_addr,
   output logic [pwg_pkg::DW-1:0]          per_wr_data,
   output logic [pwg_pkg::NPER-1:0]        prot_vec
);
   logic [pwg_pkg::NPER-1:0] prot_r;
   logic [pwg_pkg::NPER-1:0] prot_nxt;
   logic                     dbl_err;
   logic                     hit_clr;
   logic                     hit_set;
   logic                     guard_wr;
   logic                     blocked;
   pwg_pkg::pwg_rsp_t        rsp_r;
   logic                     hit_guard;

   // Low byte of a write word, one bit per peripheral
   function automatic logic [pwg_pkg::NPER-1:0] ones_of(input logic [pwg_pkg::DW-1:0] word);
      return word[pwg_pkg::NPER-1:0];
   endfunction

   // Protect vector widened to a bus word, upper bits zero
   function automatic logic [pwg_pkg::DW-1:0] guard_word(input logic [pwg_pkg::NPER-1:0] vec);
      return {{(pwg_pkg::DW-pwg_pkg::NPER){1'b0}}, vec};
   endfunction

   assign hit_clr  = req.guard_sel && (req.addr == pwg_pkg::OFF_CLR);
   assign hit_set  = req.guard_sel && (req.addr == pwg_pkg::OFF_SET);
   assign guard_wr = req.valid && req.write && (hit_clr || hit_set);
   assign blocked  = req.valid && req.write && !req.guard_sel && prot_r[req.per_idx];
   assign hit_guard = hit_clr || hit_set;

   pwg_alias_dec u_dec (
      .wr       (guard_wr),
      .is_set   (hit_set),
      .prot     (prot_r),
      .ones     (ones_of(req.wdata)),
      .prot_nxt (prot_nxt),
      .dbl_err  (dbl_err)
   );

   // Protect vector
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prot_r <= pwg_pkg::PROT_RST;
      end else begin
         prot_r <= prot_nxt;
      end
   end

   // Response to the bus master
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_r <= '0;
      end else begin
         rsp_r.done  <= req.valid;
         rsp_r.err   <= blocked || (guard_wr && dbl_err);
         rsp_r.rdata <= '0;
         if (req.valid && !req.write && hit_guard) begin
            rsp_r.rdata <= guard_word(prot_r);
         end
      end
   end

   // Forwarded peripheral writes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         per_wr_stb  <= 1'b0;
         per_wr_idx  <= '0;
         per_wr_addr <= '0;
         per_wr_data <= '0;
      end else begin
         per_wr_stb  <= req.valid && req.write && !req.guard_sel && !blocked;
         per_wr_idx  <= req.per_idx;
         per_wr_addr <= req.addr;
         per_wr_data <= req.wdata;
      end
   end

   assign rsp      = rsp_r;
   assign prot_vec = prot_r;

   sequence s_prot_wr;
      req.valid && req.write && !req.guard_sel && prot_r[req.per_idx];
   endsequence

   a_blocked_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_prot_wr |=> rsp.err && rsp.done && !per_wr_stb) else $error("protected write not refused");
   a_set_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
      guard_wr && hit_set |=> ((prot_vec & $past(req.wdata[pwg_pkg::NPER-1:0])) == $past(req.wdata[pwg_pkg::NPER-1:0])))
      else $error("set alias failed");
   a_clr_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
      guard_wr && hit_clr |=> ((prot_vec & $past(req.wdata[pwg_pkg::NPER-1:0])) == '0)) else $error("clear alias failed");
   a_zero_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
      guard_wr |=> ((prot_vec & ~$past(req.wdata[pwg_pkg::NPER-1:0])) == ($past(prot_vec) & ~$past(req.wdata[pwg_pkg::NPER-1:0]))))
      else $error("zero bits changed protection");
   a_read_same: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req.valid && !req.write && (hit_clr || hit_set) |=> rsp.rdata[pwg_pkg::NPER-1:0] == $past(prot_vec))
      else $error("alias read mismatch");
   a_dbl_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      guard_wr && hit_set && |(prot_vec & req.wdata[pwg_pkg::NPER-1:0]) |=> rsp.err) else $error("double protect missed");
   a_dbl_clr: assert property (@(posedge ref_clk) disable iff (!rst_n)
      guard_wr && hit_clr && |(~prot_vec & req.wdata[pwg_pkg::NPER-1:0]) |=> rsp.err) else $error("double unprotect missed");
   a_pass_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req.valid && !req.guard_sel && !(req.write && prot_vec[req.per_idx]) |=> rsp.done && !rsp.err)
      else $error("normal access errored");

   // Request kinds at the taking edge
   sequence s_any_req;
      req.valid;
   endsequence

   sequence s_no_req;
      !req.valid;
   endsequence

   sequence s_guard_acc;
      req.valid && req.guard_sel;
   endsequence

   sequence s_guard_rd;
      req.valid && !req.write && hit_guard;
   endsequence

   sequence s_other_guard;
      req.valid && req.guard_sel && !hit_guard;
   endsequence

   sequence s_set_clean;
      guard_wr && hit_set && ((prot_vec & ones_of(req.wdata)) == '0);
   endsequence

   sequence s_clr_clean;
      guard_wr && hit_clr && ((~prot_vec & ones_of(req.wdata)) == '0);
   endsequence

   sequence s_set_twice;
      guard_wr && hit_set && |(prot_vec & ones_of(req.wdata));
   endsequence

   sequence s_clr_twice;
      guard_wr && hit_clr && |(~prot_vec & ones_of(req.wdata));
   endsequence

   sequence s_open_per_wr;
      req.valid && req.write && !req.guard_sel && !prot_vec[req.per_idx];
   endsequence

   sequence s_per_rd;
      req.valid && !req.write && !req.guard_sel;
   endsequence

   // Answer timing, forwarding and read data
   a_done_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_any_req |=> rsp.done)
      else $error("request not answered");
   a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_no_req |=> !rsp.done && !rsp.err && !per_wr_stb)
      else $error("answer without request");
   a_guard_no_fwd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_guard_acc |=> !per_wr_stb)
      else $error("guard access forwarded");
   a_open_fwd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_open_per_wr |=> per_wr_stb && !rsp.err && (per_wr_data == $past(req.wdata))
         && (per_wr_idx == $past(req.per_idx)) && (per_wr_addr == $past(req.addr)))
      else $error("open write not forwarded");
   a_per_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_per_rd |=> rsp.done && !rsp.err && !per_wr_stb && (rsp.rdata == '0))
      else $error("peripheral read disturbed");
   a_other_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_other_guard |=> rsp.done && !rsp.err && (rsp.rdata == '0))
      else $error("unused guard offset answered");
   a_guard_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_guard_rd |=> rsp.rdata == guard_word($past(prot_vec)))
      else $error("guard read word wrong");
   a_wr_no_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
      req.valid && req.write |=> rsp.rdata == '0)
      else $error("read data on a write");
   a_err_with_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rsp.err |-> rsp.done)
      else $error("error without answer");
   a_stb_no_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
      per_wr_stb |-> !rsp.err)
      else $error("forwarded write errored");

   // Protect vector updates, their answers and reset values
   a_set_clean: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_set_clean |=> rsp.done && !rsp.err)
      else $error("clean protect errored");
   a_clr_clean: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_clr_clean |=> rsp.done && !rsp.err)
      else $error("clean unprotect errored");
   a_set_twice_apply: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_set_twice |=> rsp.err && (prot_vec == ($past(prot_vec) | $past(ones_of(req.wdata)))))
      else $error("double protect not applied");
   a_clr_twice_apply: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_clr_twice |=> rsp.err && (prot_vec == ($past(prot_vec) & ~$past(ones_of(req.wdata)))))
      else $error("double unprotect not applied");
   a_prot_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !guard_wr |=> $stable(prot_vec))
      else $error("protection changed without guard write");
   a_reset_vals: assert property (@(posedge ref_clk)
      !rst_n |-> (prot_vec == pwg_pkg::PROT_RST) && !rsp.done && !rsp.err && !per_wr_stb)
      else $error("outputs not cleared in reset");
endmodule

// >>> test/pwg_per_model.sv
// Purpose: Peripheral side that keeps what the guard forwards
// Assumes: Strobe is a one-cycle pulse
// Notes:   Holds last written word per peripheral
`timescale 1ns/10ps
module pwg_per_model (
   input  wire logic                    ref_clk,
   input  wire logic                    stb,
   input  wire logic [2:0]              idx,
   input  wire logic [pwg_pkg::DW-1:0]  data,
   output logic      [pwg_pkg::DW-1:0]  mem [8]
);
   always_ff @(posedge ref_clk) begin
      if (stb) mem[idx] <= data;
   end
endmodule

// >>> test/pwg_top_test.sv
// Purpose: Self-checking bench for the peripheral write guard
// Assumes: Answer shows from the taking edge and is checked at the next falling edge
// Notes:   Corner cases, then seeded random traffic
`timescale 1ns/10ps
module pwg_top_test;
   logic              ref_clk = 0;
   logic              rst_n;
   pwg_pkg::pwg_req_t req = '0;
   pwg_pkg::pwg_rsp_t rsp;
   logic              stb;
   logic [2:0]        widx;
   logic [11:0]       wadr;
   logic [31:0]       wdat, sh [8], mem [8];
   logic [7:0]        pv, p = pwg_pkg::PROT_RST;
   int                miscompares = 0, checks = 0;
   always #4 ref_clk = ~ref_clk;
   pwg_top pwg_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rsp(rsp), .per_wr_stb(stb),
      .per_wr_idx(widx), .per_wr_addr(wadr), .per_wr_data(wdat), .prot_vec(pv));
   pwg_per_model pwg_per_model_inst (.ref_clk(ref_clk), .stb(stb), .idx(widx), .data(wdat), .mem(mem));
   task chk(string n, logic [31:0] s, logic [31:0] e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s exp %h seen %h", n, e, s);
      end
   endtask
   task finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task op(logic g, logic w, logic [2:0] i, logic [11:0] a, logic [31:0] d);
      logic e, s;
      logic [31:0] r;
      e = 0;
      s = 0;
      r = 0;
      if (g && (a == pwg_pkg::OFF_CLR || a == pwg_pkg::OFF_SET)) begin
         if (!w) r = {24'h000000, p};
         e = w && |(d[7:0] & (a == pwg_pkg::OFF_SET ? p : ~p));
         if (w) p = (a == pwg_pkg::OFF_SET) ? (p | d[7:0]) : (p & ~d[7:0]);
      end else if (!g && w) begin
         e = p[i];
         s = !p[i];
         if (s) sh[i] = d;
      end
      req = '{1'b1, w, g, i, a, d};
      @(negedge ref_clk);
      chk("done", rsp.done, 1);
      chk("err", rsp.err, e);
      chk("stb", stb, s);
      chk("prot", pv, p);
      chk("rdata", rsp.rdata, r);
      if (s) chk("wdata", wdat, d);
      if (s) chk("widx", widx, i);
      if (s) chk("waddr", wadr, a);
   endtask
   initial begin
      logic [31:0] x, y;
      rst_n = 0;
      void'($urandom(32'ha590b19a));
      repeat (6) @(negedge ref_clk);
      rst_n = 1;
      op(1, 1, 0, pwg_pkg::OFF_SET, 32'h0000_00ff);
      op(1, 1, 0, pwg_pkg::OFF_SET, 32'h0000_0001);
      op(1, 0, 0, pwg_pkg::OFF_CLR, 0);
      op(1, 0, 0, pwg_pkg::OFF_SET, 0); // Read state before toggling
      op(0, 1, 3, 12'h010, 32'h1234_5678);
      op(1, 1, 0, pwg_pkg::OFF_CLR, 32'h0000_0000);
      op(1, 1, 0, pwg_pkg::OFF_CLR, 32'h0000_0108);
      op(1, 1, 0, pwg_pkg::OFF_CLR, 32'h0000_0108);
      op(0, 1, 3, 12'h010, 32'h1234_5678);
      op(0, 0, 5, 12'h020, 0);
      op(1, 1, 0, pwg_pkg::OFF_CLR, 32'h0000_00ff);
      for (int k = 0; k < 8; k++) op(0, 1, k[2:0], 12'h100, $urandom);
      repeat (400) begin
         x = $urandom;
         y = $urandom;
         op(x[0], x[1], x[4:2], {8'h00, x[6:5] == 2'd2, x[6:5] == 2'd1, 2'b00}, y);
      end
      // Mid-run reset
      req.valid = 0;
      rst_n = 0;
      @(negedge ref_clk);
      p = pwg_pkg::PROT_RST;
      chk("reset prot", pv, p);
      chk("reset done", rsp.done, 0);
      chk("reset stb", stb, 0);
      rst_n = 1;
      op(1, 1, 0, pwg_pkg::OFF_CLR, 32'h0000_0001);
      op(1, 0, 0, pwg_pkg::OFF_SET, 0);
      op(0, 1, 6, 12'h010, 32'h0bad_0006);
      req.valid = 0;
      repeat (2) @(negedge ref_clk);
      chk("idle done", rsp.done, 0);
      for (int k = 0; k < 8; k++) chk("mem", mem[k], sh[k]);
      finish_test;
   end
   initial begin
      #(8 * 1000);
      miscompares++;
      finish_test;
   end
endmodule
